// ==== tmr3c_core.sv ====
// timer 3 control unit: counters, reload, capture, flags and register port
//Contract
//- in split mode the high byte rolling from ff to 00 sets the high overflow flag.
//- in 16-bit mode the counter wrapping from ffff to 0000 sets the high overflow flag.
//- a set high overflow flag requests an interrupt when timer interrupts are enabled.
//- the low byte rolling from ff to 00 sets the low overflow flag in either mode.
//- low overflow interrupts only when the low irq enable and timer interrupts are on.
//- with capture enabled, each oscillator rising edge requests an interrupt; the code pulses TIMER_IRQ for it only while timer interrupts are enabled.
//- in capture mode each oscillator rising edge copies the counter into the reload bytes.
//- the split bit picks two 8-bit auto-reload timers, else one 16-bit one.
//- run control gates the timer; in split mode it gates only the high byte.
//- external clock select 0 picks system clock divided by twelve.
//- in split mode the external clock select serves both bytes.
//- per-byte clock selects pick external choice or undivided system clock.
`timescale 1ns/1ps
`include "tmr3c_consts.svh"
module tmr3c_core (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire tmr3c_pkg::tmr3c_addr_type ADDR,
   input wire tmr3c_pkg::tmr3c_byte_type WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic EXT_CLK,
   input wire logic LFOSC,
   output logic [7:0] RDATA,
   output logic IRQ,
   output logic TIMER_IRQ
);
   import tmr3c_pkg::*;
   tmr3c_tick_if tick ();
   typedef struct packed {
      logic [7:0] ctrl;
      logic [1:0] clkctl;
      logic [7:0] cnt_lo;
      logic [7:0] cnt_hi;
      logic [7:0] rld_lo;
      logic [7:0] rld_hi;
      logic [2:0] stat;
      logic [2:0] mask;
      logic tmr_ie;
      logic osc1;
      logic osc2;
      logic osc3;
      logic [7:0] rdata;
      logic irq;
      logic tirq;
   } tmr3c_state_type;
   tmr3c_state_type cur, next_cur;
   logic tick_lo, tick_hi, osc_rise, lo_wrap, hi_wrap, run_lo, run_hi, split;
   tmr3c_prescale u_pre (
      .clk(MCLK),
      .rst_n(RST_N),
      .ext_clk_pin(EXT_CLK),
      .tick(tick)
   );
   // one external choice feeds the low byte and, in split mode, the high byte; each may bypass it
   assign tick.xclk_sel = cur.ctrl[`TMR3C_BIT_XCLK];
   assign tick_lo = cur.clkctl[`TMR3C_BIT_LCLKSEL] ? 1'b1 : tick.ext_tick;
   assign split = cur.ctrl[`TMR3C_BIT_SPLIT];
   // low byte free runs in split mode
   assign run_lo = split ? 1'b1 : cur.ctrl[`TMR3C_BIT_RUN];
   assign run_hi = cur.ctrl[`TMR3C_BIT_RUN];
   assign lo_wrap = run_lo && tick_lo && (cur.cnt_lo == 8'hff);
   // high byte: own clock when split, carry of low byte otherwise
   always_comb begin
      if (split) begin
         tick_hi = cur.clkctl[`TMR3C_BIT_HCLKSEL] ? 1'b1 : tick.ext_tick;
         hi_wrap = run_hi && tick_hi && (cur.cnt_hi == 8'hff);
      end else begin
         tick_hi = lo_wrap;
         hi_wrap = lo_wrap && (cur.cnt_hi == 8'hff);
      end
   end
   // only the synchronised copies feed the edge detector
   assign osc_rise = cur.osc2 & ~cur.osc3;
   always_comb begin
      next_cur = cur;
      next_cur.osc1 = LFOSC;
      next_cur.osc2 = cur.osc1;
      next_cur.osc3 = cur.osc2;
      next_cur.rdata = 8'h00;
      // register writes first so hardware events below win over clears
      if (WR) begin
         if (ADDR == `TMR3C_ADDR_CTRL) begin
            next_cur.ctrl = WDATA & `TMR3C_CTRL_WMASK;
         end else if (ADDR == `TMR3C_ADDR_CLKCTL) begin
            next_cur.clkctl = WDATA[1:0];
         end else if (ADDR == `TMR3C_ADDR_CNT_LO) begin
            next_cur.cnt_lo = WDATA;
         end else if (ADDR == `TMR3C_ADDR_CNT_HI) begin
            next_cur.cnt_hi = WDATA;
         end else if (ADDR == `TMR3C_ADDR_RLD_LO) begin
            next_cur.rld_lo = WDATA;
         end else if (ADDR == `TMR3C_ADDR_RLD_HI) begin
            next_cur.rld_hi = WDATA;
         end else if (ADDR == `TMR3C_ADDR_IRQ_STAT) begin
            next_cur.stat = cur.stat & ~WDATA[2:0];
         end else if (ADDR == `TMR3C_ADDR_IRQ_MASK) begin
            next_cur.mask = WDATA[2:0];
         end else if (ADDR == `TMR3C_ADDR_IRQ_EN) begin
            next_cur.tmr_ie = WDATA[0];
         end
      end
      // counting with auto-reload on wrap
      if (run_lo && tick_lo) begin
         if (lo_wrap) begin
            next_cur.cnt_lo = split ? cur.rld_lo : (hi_wrap ? cur.rld_lo : 8'h00);
         end else begin
            next_cur.cnt_lo = cur.cnt_lo + 8'h01;
         end
      end
      if (run_hi && tick_hi) begin
         next_cur.cnt_hi = hi_wrap ? cur.rld_hi : cur.cnt_hi + 8'h01;
      end
      if (lo_wrap) begin
         next_cur.ctrl[`TMR3C_BIT_LOVF] = 1'b1;
         next_cur.stat[`TMR3C_EV_LOVF] = 1'b1;
      end
      if (hi_wrap) begin
         next_cur.ctrl[`TMR3C_BIT_HOVF] = 1'b1;
         next_cur.stat[`TMR3C_EV_HOVF] = 1'b1;
      end
      // capture mode: snapshot counter into reload bytes
      if (osc_rise && cur.ctrl[`TMR3C_BIT_CAPEN]) begin
         next_cur.rld_lo = cur.cnt_lo;
         next_cur.rld_hi = cur.cnt_hi;
         next_cur.stat[`TMR3C_EV_CAP] = 1'b1;
      end
      // read data one cycle after the strobe, zero otherwise
      if (RD) begin
         if (ADDR == `TMR3C_ADDR_CTRL) begin
            next_cur.rdata = cur.ctrl & `TMR3C_CTRL_WMASK;
         end else if (ADDR == `TMR3C_ADDR_CLKCTL) begin
            next_cur.rdata = {6'h00, cur.clkctl};
         end else if (ADDR == `TMR3C_ADDR_CNT_LO) begin
            next_cur.rdata = cur.cnt_lo;
         end else if (ADDR == `TMR3C_ADDR_CNT_HI) begin
            next_cur.rdata = cur.cnt_hi;
         end else if (ADDR == `TMR3C_ADDR_RLD_LO) begin
            next_cur.rdata = cur.rld_lo;
         end else if (ADDR == `TMR3C_ADDR_RLD_HI) begin
            next_cur.rdata = cur.rld_hi;
         end else if (ADDR == `TMR3C_ADDR_IRQ_STAT) begin
            next_cur.rdata = {5'h00, cur.stat};
         end else if (ADDR == `TMR3C_ADDR_IRQ_MASK) begin
            next_cur.rdata = {5'h00, cur.mask};
         end else if (ADDR == `TMR3C_ADDR_IRQ_EN) begin
            next_cur.rdata = {7'h00, cur.tmr_ie};
         end
      end
      // timer request is a level from the flags, capture is a pulse per edge
      // enable taken from the next state so the request tracks the enable register exactly
      next_cur.tirq = next_cur.tmr_ie && (next_cur.ctrl[`TMR3C_BIT_HOVF]
         || (next_cur.ctrl[`TMR3C_BIT_LOVF] && next_cur.ctrl[`TMR3C_BIT_LIEN])
         || (osc_rise && cur.ctrl[`TMR3C_BIT_CAPEN]));
      next_cur.irq = |(next_cur.stat & next_cur.mask);
   end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
   assign RDATA = cur.rdata;
   assign IRQ = cur.irq;
   assign TIMER_IRQ = cur.tirq;

   // checks
   a_high_wrap_sets_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
      hi_wrap |=> cur.ctrl[`TMR3C_BIT_HOVF]) else $error("high wrap lost");
   a_full_wrap_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
      (!split && hi_wrap && cur.rld_hi == 8'h00 && !WR) |=> cur.cnt_hi == 8'h00)
      else $error("16-bit wrap wrong");
   a_high_flag_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
      (cur.tmr_ie && cur.ctrl[`TMR3C_BIT_HOVF]) |-> TIMER_IRQ)
      else $error("missing high irq");
   a_low_wrap_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
      lo_wrap |=> cur.ctrl[`TMR3C_BIT_LOVF]) else $error("low wrap lost");
   a_low_irq_gated: assert property (@(posedge MCLK) disable iff (!RST_N)
      (!cur.ctrl[`TMR3C_BIT_HOVF] && !cur.ctrl[`TMR3C_BIT_LIEN] && !cur.ctrl[`TMR3C_BIT_CAPEN])
      |-> !TIMER_IRQ) else $error("low irq leaked");
   a_capture_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
      (osc_rise && cur.ctrl[`TMR3C_BIT_CAPEN] && cur.tmr_ie) |=> TIMER_IRQ)
      else $error("capture irq missing");
   a_capture_copy: assert property (@(posedge MCLK) disable iff (!RST_N)
      (osc_rise && cur.ctrl[`TMR3C_BIT_CAPEN]) |=> cur.rld_lo == $past(cur.cnt_lo)
      && cur.rld_hi == $past(cur.cnt_hi)) else $error("capture copy wrong");
   a_split_low_runs: assert property (@(posedge MCLK) disable iff (!RST_N)
      (split && !run_hi && tick_lo && cur.cnt_lo != 8'hff && !WR)
      |=> cur.cnt_lo == $past(cur.cnt_lo) + 8'h01) else $error("low byte stalled");
   a_flag_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
      (cur.ctrl[`TMR3C_BIT_HOVF] && !WR) |=> cur.ctrl[`TMR3C_BIT_HOVF])
      else $error("flag self-cleared");
   a_bit1_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
      (RD && ADDR == `TMR3C_ADDR_CTRL) |=> !RDATA[1]) else $error("bit1 read");
   c_split_wrap: cover property (@(posedge MCLK) disable iff (!RST_N) split && hi_wrap);
   c_full_wrap: cover property (@(posedge MCLK) disable iff (!RST_N) !split && hi_wrap);
   c_capture: cover property (@(posedge MCLK) disable iff (!RST_N)
      osc_rise && cur.ctrl[`TMR3C_BIT_CAPEN]);
endmodule

// ==== tmr3c_consts.svh ====
// register offsets, field positions, reset values and timing counts of the timer
`ifndef TMR3C_CONSTS_SVH
`define TMR3C_CONSTS_SVH
`define TMR3C_ADDR_CTRL 4'h0
`define TMR3C_ADDR_CLKCTL 4'h1
`define TMR3C_ADDR_CNT_LO 4'h2
`define TMR3C_ADDR_CNT_HI 4'h3
`define TMR3C_ADDR_RLD_LO 4'h4
`define TMR3C_ADDR_RLD_HI 4'h5
`define TMR3C_ADDR_IRQ_STAT 4'h6
`define TMR3C_ADDR_IRQ_MASK 4'h7
`define TMR3C_ADDR_IRQ_EN 4'h8
`define TMR3C_BIT_HOVF 7
`define TMR3C_BIT_LOVF 6
`define TMR3C_BIT_LIEN 5
`define TMR3C_BIT_CAPEN 4
`define TMR3C_BIT_SPLIT 3
`define TMR3C_BIT_RUN 2
`define TMR3C_BIT_XCLK 0
`define TMR3C_BIT_HCLKSEL 1
`define TMR3C_BIT_LCLKSEL 0
`define TMR3C_CTRL_RESET 8'h00
`define TMR3C_CTRL_WMASK 8'hfd
`define TMR3C_DIV_COUNT 4'hb
`define TMR3C_EV_HOVF 0
`define TMR3C_EV_LOVF 1
`define TMR3C_EV_CAP 2
`endif

// ==== tmr3c_pkg.sv ====
// types shared by the timer modules
package tmr3c_pkg;
   typedef logic [3:0] tmr3c_addr_type;
   typedef logic [7:0] tmr3c_byte_type;
endpackage

// ==== tmr3c_tick_if.sv ====
// tick bundle between the clock prescaler and the timer core
`timescale 1ns/1ps
interface tmr3c_tick_if;
   logic ext_tick;
   logic xclk_sel;
   modport src (output ext_tick, input xclk_sel);
   modport dst (input ext_tick, output xclk_sel);
endinterface

// ==== tmr3c_prescale.sv ====
// external clock choice: system clock divided by twelve or synchronised pin edges
`timescale 1ns/1ps
`include "tmr3c_consts.svh"
module tmr3c_prescale (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ext_clk_pin,
   tmr3c_tick_if.src tick
);
   import tmr3c_pkg::*;
   typedef struct packed {
      logic [3:0] div;
      logic sync1;
      logic sync2;
      logic sync3;
      logic tick;
   } tmr3c_pre_type;
   tmr3c_pre_type cur, next_cur;
   // divider free runs so the choice can switch at any time
   always_comb begin
      next_cur = cur;
      next_cur.sync1 = ext_clk_pin;
      next_cur.sync2 = cur.sync1;
      next_cur.sync3 = cur.sync2;
      next_cur.div = (cur.div == `TMR3C_DIV_COUNT) ? 4'h0 : cur.div + 4'h1;
      if (tick.xclk_sel) begin
         next_cur.tick = cur.sync2 & ~cur.sync3; // pin rising edge
      end else begin
         next_cur.tick = (cur.div == `TMR3C_DIV_COUNT);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
   assign tick.ext_tick = cur.tick;
endmodule

// ==== tb_top.sv ====
// self-checking testbench of the timer control unit over its register port
`timescale 1ns/1ps
module tb_top;
   import tmr3c_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   tmr3c_addr_type addr;
   tmr3c_byte_type wdata;
   logic wr, rd, ext_clk, lfosc, irq, timer_irq;
   logic [7:0] rdata, v;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   int n_tirq = 0;
   int k;

   // 40 MHz system clock
   always #12.5 mclk = ~mclk;

   tmr3c_core i_dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .EXT_CLK(ext_clk), .LFOSC(lfosc), .RDATA(rdata), .IRQ(irq),
      .TIMER_IRQ(timer_irq));

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (timer_irq === 1'b1) n_tirq++;
      if (cycles == 5000) begin
         n_fail++;
         $display("mismatch at %0t: run did not finish", $time);
         final_report();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one-cycle write strobe; a cycle passes before the next request
   task automatic wrr(input tmr3c_addr_type a, input tmr3c_byte_type d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rdd(input tmr3c_addr_type a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rdc(input tmr3c_addr_type a, input logic [7:0] exp);
      logic [7:0] d;
      rdd(a, d);
      chk(d, exp);
   endtask

   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ext_clk = 1'b0;
      lfosc = 1'b0;
      idle(12);
      rst_n <= 1'b1;
      rdc(4'h0, 8'h00);
      wrr(4'h0, 8'hff);
      rdc(4'h0, 8'hfd);
      wrr(4'h0, 8'h00);
      rdc(4'h0, 8'h00);
      rdc(4'h9, 8'h00);
      // 16-bit wrap from ffff with both bytes on the undivided clock
      wrr(4'h1, 8'h03);
      wrr(4'h4, 8'h00);
      wrr(4'h5, 8'h00);
      wrr(4'h3, 8'hff);
      wrr(4'h2, 8'hf0);
      wrr(4'h8, 8'h01);
      wrr(4'h7, 8'h03);
      wrr(4'h0, 8'h04);
      idle(40);
      rdc(4'h0, 8'hc4);
      rdc(4'h6, 8'h03);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, timer_irq}, 8'h01);
      wrr(4'h0, 8'h00);
      wrr(4'h6, 8'h03);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      // split mode, run off: only the low byte advances
      wrr(4'h3, 8'hff);
      wrr(4'h2, 8'hf0);
      wrr(4'h0, 8'h08);
      idle(40);
      rdc(4'h0, 8'h48);
      rdc(4'h3, 8'hff);
      chk({7'h00, timer_irq}, 8'h00);
      wrr(4'h0, 8'h68);
      idle(3);
      chk({7'h00, timer_irq}, 8'h01);
      // split mode, run on: high byte rolls over on its own
      wrr(4'h3, 8'hf0);
      wrr(4'h0, 8'h0c);
      idle(40);
      rdd(4'h0, v);
      chk(v & 8'h80, 8'h80);
      wrr(4'h0, 8'h00);
      wrr(4'h6, 8'h07);
      rdc(4'h6, 8'h00);
      // divided system clock: one tick per twelve cycles, phase unknown
      wrr(4'h1, 8'h00);
      wrr(4'h3, 8'h00);
      wrr(4'h2, 8'h00);
      wrr(4'h0, 8'h04);
      idle(120);
      wrr(4'h0, 8'h00);
      rdd(4'h2, v);
      chk({7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
      // pin clock shared by both bytes in split mode
      wrr(4'h2, 8'h00);
      wrr(4'h3, 8'h00);
      wrr(4'h0, 8'h0d);
      repeat (5) begin
         ext_clk <= 1'b1;
         idle(4);
         ext_clk <= 1'b0;
         idle(4);
      end
      idle(4);
      wrr(4'h0, 8'h01);
      rdc(4'h2, 8'h05);
      rdc(4'h3, 8'h05);
      // capture of a stopped counter on an oscillator rising edge
      wrr(4'h3, 8'h12);
      wrr(4'h2, 8'h34);
      wrr(4'h0, 8'h10);
      k = n_tirq;
      lfosc <= 1'b1;
      idle(8);
      lfosc <= 1'b0;
      idle(4);
      chk(8'(n_tirq - k), 8'h01);
      rdc(4'h4, 8'h34);
      rdc(4'h5, 8'h12);
      rdc(4'h6, 8'h04);
      // mask gates the level output, write one clears the status
      wrr(4'h7, 8'h00);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      wrr(4'h7, 8'h04);
      idle(2);
      chk({7'h00, irq}, 8'h01);
      wrr(4'h6, 8'h04);
      idle(2);
      chk({7'h00, irq}, 8'h00);
      final_report();
   end
endmodule
